// ---- pkg/acsc_defs.vh ----
// cycle state codes, layer layout and timing counts for the bus cycle classifier
`ifndef ACSC_DEFS_VH
`define ACSC_DEFS_VH

// ------------------------------------------------------------
// bus transfer and response encodings
// ------------------------------------------------------------
`define ACSC_TRANS_IDLE 2'h0
`define ACSC_TRANS_BUSY 2'h1
`define ACSC_TRANS_NSEQ 2'h2
`define ACSC_TRANS_SEQ 2'h3
`define ACSC_RESP_OKAY 2'h0
`define ACSC_RESP_ERROR 2'h1
`define ACSC_RESP_RETRY 2'h2
`define ACSC_RESP_SPLIT 2'h3

// ------------------------------------------------------------
// cycle state codes
// ------------------------------------------------------------
`define ACSC_ST_IDLE 6'h00
`define ACSC_ST_SEQ_INCR 6'h01
`define ACSC_ST_BUSY 6'h02
`define ACSC_ST_SEQ_INCR4 6'h03
`define ACSC_ST_SEQ_WRAP8 6'h04
`define ACSC_ST_SEQ_INCR8 6'h05
`define ACSC_ST_ERROR_NEXT 6'h06
`define ACSC_ST_RETRY_NEXT 6'h06
`define ACSC_ST_SEQ_INCR16 6'h07
`define ACSC_ST_NR_BASE 6'h08
`define ACSC_ST_STALL_TARGET 6'h0C
`define ACSC_ST_STALL_MATRIX 6'h0D
`define ACSC_ST_STALL_ARB 6'h0E
`define ACSC_ST_NW_BASE 6'h10
`define ACSC_ST_SEQ_WRAP4 6'h1A
`define ACSC_ST_SEQ_WRAP16 6'h1B
`define ACSC_ST_NR_HIGH_BASE 6'h1C

// ------------------------------------------------------------
// packet layout: layer 0 lcd .. 6 gxi
// ------------------------------------------------------------
`define ACSC_LAYERS 7
`define ACSC_PKT_W 33
`define ACSC_LSB_LCD 0
`define ACSC_LSB_EXP 4
`define ACSC_LSB_DMA1 9
`define ACSC_LSB_DMA0 14
`define ACSC_LSB_ARMI 19
`define ACSC_LSB_ARMD 23
`define ACSC_LSB_GXI 29
`define ACSC_MASK_LCD 32'h0000FFEF
`define ACSC_MASK_EXP 32'hFC7F7FFF
`define ACSC_MASK_DMA1 32'h801F7FEB
`define ACSC_MASK_DMA0 32'h902373EB
`define ACSC_MASK_ARMI 32'h0000FF59
`define ACSC_MASK_ARMD 32'h707F7F79
`define ACSC_MASK_GXI 32'h0000FFFF

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define ACSC_LAG_CYCLES 3
`define ACSC_PKT_REG_STAGES 1

`endif

// ---- src/acsc_delay.v ----
// fixed-depth register delay line for the trace packet
`timescale 1ns/1ns
module acsc_delay #(
  parameter WIDTH = 33,
  parameter DEPTH = 2
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // data
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  // ------------------------------------------------------------
  // stages
  // ------------------------------------------------------------
  // one register per stage, each with a single driver
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : gen_stage
      reg [WIDTH-1:0] q;
      wire [WIDTH-1:0] d;
      if (g == 0) begin : gen_first
        assign d = din;
      end else begin : gen_next
        assign d = gen_stage[g-1].q;
      end
      always @(posedge sys_clk) begin
        if (rst) begin
          q <= {WIDTH{1'b0}};
        end else begin
          q <= d;
        end
      end
    end
  endgenerate

  assign dout = gen_stage[DEPTH-1].q;

endmodule

// ---- src/acsc_classifier.v ----
// per-layer bus cycle classifier feeding the 33-bit trace packet
//
// Operation
// - idle transfer completing gives the idle state
// - busy transfer completing gives the busy state
// - first cycle of a two-cycle error response gives error-next
// - first cycle of a two-cycle retry response gives retry-next; second cycle free
// - wait inserted by the addressed slave gives stall_target
// - wait while the matrix sets up a connection gives stall_matrix_connect
// - wait from arbitration between masters gives stall_arbitration
// - completed sequential beat gives a state per burst type
// - completed nonsequential read gives a state naming the source slave, the idle state for slave seven
// - completed nonsequential write gives a state naming the written slave
// - sequential states carry no direction and no slave number
// - nonsequential states carry no burst type
// - each layer emits only the states its master can produce
// - one wait state per wait cycle, completion state only in last cycle
// - stretched wrap-four beats give stall_target then seq_wrap_burst_of_four
// - fixed base codes for idle, busy, error-next and the three waits
// - all layers packed in one 33-bit packet each clock, fixed widths
// - packet appears on the trace port three clocks after the bus cycle
`timescale 1ns/1ns
`include "acsc_defs.vh"
module acsc_classifier (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // observed layers, 0 lcd, 1 exp, 2 dma1, 3 dma0, 4 cpu-i, 5 cpu-d, 6 gxi
  input wire [2*`ACSC_LAYERS-1:0] lay_trans,
  input wire [`ACSC_LAYERS-1:0] lay_write,
  input wire [3*`ACSC_LAYERS-1:0] lay_burst,
  input wire [3*`ACSC_LAYERS-1:0] lay_slave,
  input wire [2*`ACSC_LAYERS-1:0] lay_resp,
  input wire [`ACSC_LAYERS-1:0] lay_ready,
  // wait causes from the matrix and arbiter
  input wire [`ACSC_LAYERS-1:0] lay_matrix_wait,
  input wire [`ACSC_LAYERS-1:0] lay_arb_wait,
  // trace output
  output wire [`ACSC_PKT_W-1:0] trace_output_port
);

  // ------------------------------------------------------------
  // layer layout
  // ------------------------------------------------------------
  // field bounds of each layer in the packet
  function integer lay_lsb;
    input integer i;
    begin
      case (i)
        0: lay_lsb = `ACSC_LSB_LCD;
        1: lay_lsb = `ACSC_LSB_EXP;
        2: lay_lsb = `ACSC_LSB_DMA1;
        3: lay_lsb = `ACSC_LSB_DMA0;
        4: lay_lsb = `ACSC_LSB_ARMI;
        5: lay_lsb = `ACSC_LSB_ARMD;
        default: lay_lsb = `ACSC_LSB_GXI;
      endcase
    end
  endfunction

  function integer lay_msb;
    input integer i;
    begin
      if (i == `ACSC_LAYERS-1) begin
        lay_msb = `ACSC_PKT_W-1;
      end else begin
        lay_msb = lay_lsb(i+1)-1;
      end
    end
  endfunction

  function [31:0] lay_mask;
    input integer i;
    begin
      case (i)
        0: lay_mask = `ACSC_MASK_LCD;
        1: lay_mask = `ACSC_MASK_EXP;
        2: lay_mask = `ACSC_MASK_DMA1;
        3: lay_mask = `ACSC_MASK_DMA0;
        4: lay_mask = `ACSC_MASK_ARMI;
        5: lay_mask = `ACSC_MASK_ARMD;
        default: lay_mask = `ACSC_MASK_GXI;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // code decoders
  // ------------------------------------------------------------
  // sequential code depends on burst type only
  function [5:0] seq_code;
    input [2:0] burst;
    begin
      case (burst)
        3'h2: seq_code = `ACSC_ST_SEQ_WRAP4;
        3'h3: seq_code = `ACSC_ST_SEQ_INCR4;
        3'h4: seq_code = `ACSC_ST_SEQ_WRAP8;
        3'h5: seq_code = `ACSC_ST_SEQ_INCR8;
        3'h6: seq_code = `ACSC_ST_SEQ_WRAP16;
        3'h7: seq_code = `ACSC_ST_SEQ_INCR16;
        default: seq_code = `ACSC_ST_SEQ_INCR;
      endcase
    end
  endfunction

  // nonsequential code depends on direction and slave only
  function [5:0] nseq_code;
    input write;
    input [2:0] slave;
    begin
      if (write) begin
        nseq_code = `ACSC_ST_NW_BASE + {3'h0, slave};
      end else if (slave == 3'h7) begin
        // no slave behind number seven; report the idle code
        nseq_code = `ACSC_ST_IDLE;
      end else if (slave < 3'h4) begin
        nseq_code = `ACSC_ST_NR_BASE + {3'h0, slave};
      end else begin
        nseq_code = `ACSC_ST_NR_HIGH_BASE + {3'h0, slave} - 6'h04;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // per-layer classification
  // ------------------------------------------------------------
  wire [`ACSC_PKT_W-1:0] next_packet;
  reg [`ACSC_PKT_W-1:0] packet;
  // packet register plus the delay stages make up the full lag
  localparam DELAY_DEPTH = `ACSC_LAG_CYCLES - `ACSC_PKT_REG_STAGES;

  genvar g;
  generate
    for (g = 0; g < `ACSC_LAYERS; g = g + 1) begin : gen_layer
      localparam LSB = lay_lsb(g);
      localparam MSB = lay_msb(g);
      localparam [31:0] MASK = lay_mask(g);

      wire [1:0] trans = lay_trans[2*g +: 2];
      wire [1:0] resp = lay_resp[2*g +: 2];
      wire ready = lay_ready[g];

      // address phase held for the data phase
      // the bus holds it through waits, so take it only on ready
      reg [1:0] dp_trans;
      reg dp_write;
      reg [2:0] dp_burst;
      reg [2:0] dp_slave;
      reg [5:0] code;
      reg [5:0] done_code;

      always @(posedge sys_clk) begin
        if (rst) begin
          dp_trans <= `ACSC_TRANS_IDLE;
          dp_write <= 1'b0;
          dp_burst <= 3'h0;
          dp_slave <= 3'h0;
        end else if (ready) begin
          dp_trans <= trans;
          dp_write <= lay_write[g];
          dp_burst <= lay_burst[3*g +: 3];
          dp_slave <= lay_slave[3*g +: 3];
        end
      end

      always @* begin
        // completion code of the held data phase
        case (dp_trans)
          `ACSC_TRANS_IDLE: done_code = `ACSC_ST_IDLE;
          `ACSC_TRANS_BUSY: done_code = `ACSC_ST_BUSY;
          `ACSC_TRANS_SEQ: done_code = seq_code(dp_burst);
          `ACSC_TRANS_NSEQ: done_code = nseq_code(dp_write, dp_slave);
          default: done_code = `ACSC_ST_IDLE;
        endcase
        // codes this master cannot produce are never emitted
        if (!MASK[done_code[4:0]]) begin
          done_code = `ACSC_ST_IDLE;
        end
        // response first half beats any wait cause
        if (!ready && resp == `ACSC_RESP_ERROR) begin
          code = `ACSC_ST_ERROR_NEXT;
        end else if (!ready && (resp == `ACSC_RESP_RETRY || resp == `ACSC_RESP_SPLIT)) begin
          code = `ACSC_ST_RETRY_NEXT;
        end else if (!ready && lay_matrix_wait[g]) begin
          code = `ACSC_ST_STALL_MATRIX;
        end else if (!ready && lay_arb_wait[g]) begin
          code = `ACSC_ST_STALL_ARB;
        end else if (!ready) begin
          code = `ACSC_ST_STALL_TARGET;
        end else begin
          code = done_code;
        end
      end

      // narrow layers keep only the low code bits
      assign next_packet[MSB:LSB] = code[MSB-LSB:0];
    end
  endgenerate

  // ------------------------------------------------------------
  // packet register and output delay
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      packet <= {`ACSC_PKT_W{1'b0}};
    end else begin
      packet <= next_packet;
    end
  end

  acsc_delay #(
    .WIDTH(`ACSC_PKT_W),
    .DEPTH(DELAY_DEPTH)
  ) u_delay (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(packet),
    .dout(trace_output_port)
  );

endmodule

// ---- testbench/acsc_classifier_sva.sv ----
// port assertions for the bus cycle classifier
`timescale 1ns/1ns
module acsc_chk (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // observed layers
  input wire [13:0] lay_trans,
  input wire [6:0] lay_write,
  input wire [20:0] lay_burst,
  input wire [20:0] lay_slave,
  input wire [13:0] lay_resp,
  input wire [6:0] lay_ready,
  input wire [6:0] lay_matrix_wait,
  input wire [6:0] lay_arb_wait,
  // trace output
  input wire [32:0] trace_output_port
);
  // expansion layer fields
  wire r = lay_ready[1];
  wire m = lay_matrix_wait[1];
  wire a = lay_arb_wait[1];
  wire [1:0] rs = lay_resp[3:2];
  wire [1:0] tr = lay_trans[3:2];
  wire [4:0] f = trace_output_port[8:4];
  // address phase as the bus holds it for the data phase
  logic [1:0] ap_tr;
  logic ap_wr;
  logic [2:0] ap_bu;
  logic [2:0] ap_sl;
  always @(posedge sys_clk) begin
    if (rst) begin
      ap_tr <= 2'h0;
      ap_wr <= 1'b0;
      ap_bu <= 3'h0;
      ap_sl <= 3'h0;
    end else if (r) begin
      ap_tr <= tr;
      ap_wr <= lay_write[1];
      ap_bu <= lay_burst[5:3];
      ap_sl <= lay_slave[5:3];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  stall_tgt_a: assert property (!r && rs == 2'h0 && !m && !a |-> ##3 f == 5'h0C) else $error("slave wait");
  stall_mtx_a: assert property (!r && rs == 2'h0 && m |-> ##3 f == 5'h0D) else $error("matrix wait");
  stall_arb_a: assert property (!r && rs == 2'h0 && !m && a |-> ##3 f == 5'h0E) else $error("arb wait");
  err_first_a: assert property (!r && rs == 2'h1 |-> ##3 f == 5'h06) else $error("error half");
  retry_first_a: assert property (!r && rs[1] |-> ##3 f == 5'h06) else $error("retry half");
  idle_done_a: assert property (r && ap_tr == 2'h0 |-> ##3 f == 5'h00) else $error("idle");
  busy_done_a: assert property (r && ap_tr == 2'h1 |-> ##3 f == 5'h02) else $error("busy");
  wrap_beat_a: assert property (r && ap_tr == 2'h3 && ap_bu == 3'h2 |->
    ##3 f == 5'h1A) else $error("wrap beat");
  write_slave_a: assert property (r && ap_tr == 2'h2 && ap_wr && ap_sl != 3'h7 |->
    ##3 f == (5'h10 | {2'h0, $past(ap_sl, 3)})) else $error("write code");
  rst_clear_a: assert property (disable iff (1'b0) rst |=> trace_output_port == 33'h0) else $error("reset");
endmodule
bind acsc_classifier acsc_chk u_chk (.sys_clk(sys_clk), .rst(rst), .lay_trans(lay_trans),
  .lay_write(lay_write), .lay_burst(lay_burst), .lay_slave(lay_slave), .lay_resp(lay_resp),
  .lay_ready(lay_ready), .lay_matrix_wait(lay_matrix_wait), .lay_arb_wait(lay_arb_wait),
  .trace_output_port(trace_output_port));

// ---- testbench/acsc_bus_model.sv ----
// layer masters, matrix, arbiter and slaves seen by the classifier
`timescale 1ns/1ns
module acsc_bus_model (
  // layer signals
  output logic [13:0] lay_trans,
  output logic [6:0] lay_write,
  output logic [20:0] lay_burst,
  output logic [20:0] lay_slave,
  output logic [13:0] lay_resp,
  output logic [6:0] lay_ready,
  // wait causes
  output logic [6:0] lay_matrix_wait,
  output logic [6:0] lay_arb_wait
);
  logic tog = 1'b0;
  // ----
  // one cycle, layer l active
  // ----
  task cyc(input int l, input [1:0] tr, input wr, input [2:0] bu, input [2:0] sl, input [4:0] c);
    logic [13:0] t, p;
    logic [6:0] w, y, m, a;
    logic [20:0] b, s;
    tog = ~tog;
    t = '0;
    p = '0;
    w = {7{tog}};
    b = {21{tog}};
    s = {21{tog}};
    y = '1;
    m = '0;
    a = '0;
    t[2*l+:2] = tr;
    w[l] = wr;
    b[3*l+:3] = bu;
    s[3*l+:3] = sl;
    {p[2*l+:2], y[l], a[l], m[l]} = c;
    // each port written once per cycle
    lay_trans = t;
    lay_write = w;
    lay_burst = b;
    lay_slave = s;
    lay_resp = p;
    lay_ready = y;
    lay_matrix_wait = m;
    lay_arb_wait = a;
  endtask
  initial begin
    cyc(0, 2'h0, 1'h0, 3'h0, 3'h0, 5'h04);
  end
endmodule

// ---- testbench/acsc_classifier_tb_top.sv ----
// self-checking bench for the bus cycle classifier
`timescale 1ns/1ns
`include "acsc_defs.vh"
module acsc_classifier_tb_top;
  localparam logic [1:0] tr_i = 2'h0, tr_b = 2'h1, tr_n = 2'h2, tr_s = 2'h3;
  localparam logic [4:0] c_done = 5'h04, c_slv = 5'h00, c_mtx = 5'h01, c_arb = 5'h02;
  localparam logic [4:0] c_err1 = 5'h08, c_err2 = 5'h0C, c_rty1 = 5'h11, c_rty2 = 5'h14;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  wire [13:0] lay_trans, lay_resp;
  wire [6:0] lay_write, lay_ready, lay_matrix_wait, lay_arb_wait;
  wire [20:0] lay_burst, lay_slave;
  wire [32:0] trace_output_port;
  int err_total = 0;
  int n_tests = 0;
  int lsb[7] = '{`ACSC_LSB_LCD, `ACSC_LSB_EXP, `ACSC_LSB_DMA1, `ACSC_LSB_DMA0,
    `ACSC_LSB_ARMI, `ACSC_LSB_ARMD, `ACSC_LSB_GXI};
  logic [32:0] exq[$];
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  acsc_bus_model bus (.lay_trans(lay_trans), .lay_write(lay_write), .lay_burst(lay_burst),
    .lay_slave(lay_slave), .lay_resp(lay_resp), .lay_ready(lay_ready),
    .lay_matrix_wait(lay_matrix_wait), .lay_arb_wait(lay_arb_wait));
  acsc_classifier DUT (.sys_clk(sys_clk), .rst(rst), .lay_trans(lay_trans), .lay_write(lay_write),
    .lay_burst(lay_burst), .lay_slave(lay_slave), .lay_resp(lay_resp), .lay_ready(lay_ready),
    .lay_matrix_wait(lay_matrix_wait), .lay_arb_wait(lay_arb_wait), .trace_output_port(trace_output_port));
  task check(input [32:0] seen, input [32:0] want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // drive one cycle; packet of three cycles back is judged first
  task step(input int l, input [1:0] tr, input wr, input [2:0] bu, input [2:0] sl, input [4:0] c, input [5:0] e);
    @(negedge sys_clk);
    if (exq.size() == 3) check(trace_output_port, exq.pop_front());
    bus.cyc(l, tr, wr, bu, sl, c);
    exq.push_back(33'(e) << lsb[l]);
  endtask
  task done(input string s);
    repeat (3) step(0, tr_i, 1'h0, 3'h0, 3'h0, c_done, 6'h00);
    $display("%s finished, mismatches %0d", s, err_total);
  endtask
  task t_walk;
    step(1, tr_n, 1'h1, 3'h3, 3'h1, c_done, 6'h00);
    step(1, tr_s, 1'h1, 3'h3, 3'h1, c_mtx, 6'h0D);
    step(1, tr_s, 1'h1, 3'h3, 3'h1, c_done, 6'h11);
    repeat (2) step(1, tr_s, 1'h1, 3'h3, 3'h1, c_done, 6'h03);
    step(1, tr_n, 1'h0, 3'h2, 3'h2, c_done, 6'h03);
    step(1, tr_n, 1'h0, 3'h2, 3'h2, c_mtx, 6'h0D);
    step(1, tr_n, 1'h0, 3'h2, 3'h2, c_arb, 6'h0E);
    step(1, tr_s, 1'h0, 3'h2, 3'h2, c_done, 6'h0A);
    for (int k = 0; k < 3; k++) begin
      step(1, tr_s, 1'h0, 3'h2, 3'h2, c_slv, 6'h0C);
      step(1, k < 2 ? tr_s : tr_i, 1'h0, 3'h2, 3'h2, c_done, 6'h1A);
    end
    done("walk");
  endtask
  task t_resp;
    step(1, tr_b, 1'h0, 3'h0, 3'h0, c_done, 6'h00);
    step(1, tr_n, 1'h0, 3'h0, 3'h5, c_done, 6'h02);
    step(1, tr_i, 1'h0, 3'h0, 3'h0, c_err1, 6'h06);
    step(1, tr_n, 1'h1, 3'h0, 3'h0, c_err2, 6'h1D);
    step(1, tr_i, 1'h0, 3'h0, 3'h0, c_rty1, 6'h06);
    step(1, tr_i, 1'h0, 3'h0, 3'h0, c_rty2, 6'h10);
    step(1, tr_i, 1'h0, 3'h0, 3'h0, 5'h1A, 6'h06);
    step(1, tr_i, 1'h0, 3'h0, 3'h0, 5'h1C, 6'h00);
    done("resp");
  endtask
  task t_mask;
    step(0, tr_n, 1'h1, 3'h0, 3'h2, c_done, 6'h00);
    step(4, tr_s, 1'h0, 3'h1, 3'h0, c_done, 6'h00);
    step(5, tr_n, 1'h0, 3'h0, 3'h6, c_done, 6'h00);
    step(5, tr_i, 1'h0, 3'h0, 3'h0, c_done, 6'h1E);
    done("mask");
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    t_walk;
    t_resp;
    t_mask;
    finish_test;
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    err_total++;
    finish_test;
  end
endmodule
